// [sdc_pkg.sv]
// sdc_pkg: shared constants and types of the converter calibration controller
package sdc_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] SDC_MODE_OFF = 8'h00;
   localparam logic [7:0] SDC_STAT_OFF = 8'h04;
   localparam logic [7:0] SDC_MASK_OFF = 8'h08;
   localparam logic [7:0] SDC_RATE_OFF = 8'h0C;
   localparam logic [7:0] SDC_DATA0_OFF = 8'h10;
   localparam logic [7:0] SDC_DATA1_OFF = 8'h14;
   localparam logic [7:0] SDC_OFS0_OFF = 8'h18;
   localparam logic [7:0] SDC_GAIN0_OFF = 8'h1C;
   localparam logic [7:0] SDC_OFS1_OFF = 8'h20;
   localparam logic [7:0] SDC_GAIN1_OFF = 8'h24;
   // ==========================================
   // mode register fields
   localparam int SDC_MODE_LSB = 0;
   localparam int SDC_EN0_BIT = 4;
   localparam int SDC_EN1_BIT = 5;
   // status register fields
   localparam int SDC_PRIMARY_READY_FLAG_BIT = 0;
   localparam int SDC_AUXILIARY_READY_FLAG_BIT = 1;
   localparam int SDC_PRIMARY_ERROR_FLAG_BIT = 2;
   localparam int SDC_AUXILIARY_ERROR_FLAG_BIT = 3;
   localparam int SDC_NOREF_BIT = 4;
   localparam logic [3:0] SDC_STICKY_MASK = 4'hF;
   // ==========================================
   // mode field encodings
   localparam logic [2:0] SDC_MODE_IDLE = 3'h0;
   localparam logic [2:0] SDC_MODE_NORMAL = 3'h1;
   localparam logic [2:0] SDC_MODE_INT_ZERO = 3'h4;
   localparam logic [2:0] SDC_MODE_INT_FULL = 3'h5;
   localparam logic [2:0] SDC_MODE_SYS_ZERO = 3'h6;
   localparam logic [2:0] SDC_MODE_SYS_FULL = 3'h7;
   // ==========================================
   // reset values and rates
   localparam logic [7:0] SDC_RATE_RESET = 8'h45;
   localparam logic [7:0] SDC_RATE_SLOWEST = 8'hFF;
   localparam logic [23:0] SDC_GAIN_UNITY = 24'h800000;
   localparam int SDC_GAIN_FRAC = 23;
   // modulator input selection
   typedef enum logic [1:0] {SDC_IN_PINS, SDC_IN_ZERO, SDC_IN_FULL} sdc_insel_t;
   // filter word from the digital filter
   typedef struct packed {
      logic valid;
      logic chan;
      logic [23:0] word;
   } sdc_filt_t;
endpackage : sdc_pkg

// [sdc_corr.sv]
// sdc_corr: offset subtraction and gain scaling of one filter word
`timescale 1ns/10ps
`default_nettype none
module sdc_corr
   import sdc_pkg::*;
#(
   parameter int W = 24
) (
   input wire logic [W-1:0] raw, // filter word
   input wire logic [W-1:0] ofs, // offset coefficient
   input wire logic [W-1:0] gain, // gain coefficient
   output logic [W-1:0] res // corrected word
);
   logic signed [W:0] diff;
   logic signed [2*W+1:0] prod;
   logic signed [2*W+1:0] shifted;
   always_comb begin
      diff = $signed({1'b0, raw}) - $signed({1'b0, ofs});
      prod = diff * $signed({1'b0, gain});
      shifted = prod >>> SDC_GAIN_FRAC;
      if (shifted < 0) begin
         res = '0;
      end else if (shifted > $signed({{(W+2){1'b0}}, {W{1'b1}}})) begin
         res = {W{1'b1}};
      end else begin
         res = shifted[W-1:0];
      end
   end
endmodule : sdc_corr
`default_nettype wire

// [sdc_rate.sv]
// sdc_rate: divider giving one output-update pulse per filter period
`timescale 1ns/10ps
`default_nettype none
module sdc_rate #(
   parameter int DIV = 16
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic restart, // restart the period
   input wire logic [7:0] rate, // filter rate word
   output logic tick // update pulse
);
   logic [15:0] cnt_r;
   logic [15:0] limit;
   assign limit = 16'((32'(rate) + 1) * DIV - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (restart) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r >= limit) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : sdc_rate
`default_nettype wire

// [sdc_cal.sv]
// sdc_cal: two-channel converter calibration controller with APB registers
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - four calibration modes, internal or system and zero or full scale, are chosen by the mode field.
// - after power-on the factory offset and gain of both channels are copied into the coefficient registers.
// - a calibration of an enabled channel replaces that channel's coefficient with the measured value.
// - zero-scale and full-scale points are each measured by a conversion.
// - a zero-scale result is stored in the channel's offset register.
// - a full-scale result is stored in the channel's gain register.
// - internal modes switch the zero or full-scale reference onto the modulator input.
// - every calibration conversion runs at the slowest update rate.
// - gain coefficients are normalized before they are applied.
// - filter words have the offset subtracted first and are then scaled by the gain.
// - completion of a calibration sets the channel ready bit as a conversion does.
// - a missing reference during calibration blocks the update and sets the channel error bit.
// - the rate word goes to 255, the slowest rate, used for calibration.
module sdc_cal
   import sdc_pkg::*;
#(
   parameter int DIV = 16,
   parameter int W = 24
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire sdc_pkg::sdc_filt_t filt, // filter word in
   input wire logic missing_reference_flag, // reference detector
   input wire logic [W-1:0] fact_ofs0, // factory offset primary
   input wire logic [W-1:0] fact_gain0, // factory gain primary
   input wire logic [W-1:0] fact_ofs1, // factory offset auxiliary
   input wire logic [W-1:0] fact_gain1, // factory gain auxiliary
   output sdc_pkg::sdc_insel_t insel0, // primary modulator input
   output sdc_pkg::sdc_insel_t insel1, // auxiliary modulator input
   output logic [7:0] filter_rate_word, // rate in use by the filter
   output logic filt_restart, // one-cycle filter restart
   output logic irq // interrupt, high
);
   // ==========================================
   // bus decode
   logic wr_en;
   logic addr_ok;
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= SDC_GAIN1_OFF);
   assign pslverr = psel && penable && !addr_ok;

   // ==========================================
   // registers
   logic [5:0] mode_r;
   logic [3:0] stat_r;
   logic [3:0] mask_r;
   logic [7:0] rate_r;
   logic [W-1:0] data0_r;
   logic [W-1:0] data1_r;
   logic [W-1:0] ofs0_r;
   logic [W-1:0] gain0_r;
   logic [W-1:0] ofs1_r;
   logic [W-1:0] gain1_r;
   logic loaded_r;
   logic [2:0] mfield;
   logic is_zero;
   logic is_int;
   logic [1:0] chan_en;
   assign mfield = mode_r[SDC_MODE_LSB+2:SDC_MODE_LSB];
   assign chan_en = {mode_r[SDC_EN1_BIT], mode_r[SDC_EN0_BIT]};
   // calibration mode decode
   // four calibration modes
   assign is_zero = !mfield[0];
   assign is_int = !mfield[1];

   // ==========================================
   // calibration sequencing
   typedef enum logic [1:0] {SDC_IDLE, SDC_SETTLE, SDC_MEAS} sdc_state_t;
   sdc_state_t state_r;
   logic [1:0] cal_ch_r;
   logic noref_seen_r;
   logic [1:0] cal_pts_r;
   logic tick;
   logic start;
   logic cal_done;
   logic mode_wr;
   assign mode_wr = wr_en && (paddr == SDC_MODE_OFF);
   assign start = mode_wr && pwdata[SDC_MODE_LSB+2] && (pwdata[SDC_EN1_BIT:SDC_EN0_BIT] != 2'b00);
   assign cal_done = (state_r == SDC_MEAS) && tick;
   assign filt_restart = start;

   // slowest rate while calibrating
   // slowest rate
   assign filter_rate_word = (state_r != SDC_IDLE) ? SDC_RATE_SLOWEST : rate_r;

   sdc_rate #(.DIV(DIV)) u_rate (
      .pclk(pclk),
      .presetn(presetn),
      .restart(start),
      .rate(filter_rate_word),
      .tick(tick)
   );

   // one settling period for chopping, then the measuring period
   // conversion per point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SDC_IDLE;
         cal_ch_r <= 2'b00;
      end else begin
         case (state_r)
            SDC_IDLE: begin
               if (start) begin
                  state_r <= SDC_SETTLE;
                  cal_ch_r <= pwdata[SDC_EN1_BIT:SDC_EN0_BIT];
               end
            end
            SDC_SETTLE: begin
               if (tick) begin
                  state_r <= SDC_MEAS;
               end
            end
            SDC_MEAS: begin
               if (tick) begin
                  state_r <= SDC_IDLE;
               end
            end
            default: state_r <= SDC_IDLE;
         endcase
      end
   end

   // missing reference anywhere in the calibration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         noref_seen_r <= 1'b0;
      end else if (start) begin
         noref_seen_r <= missing_reference_flag;
      end else if (state_r != SDC_IDLE && missing_reference_flag) begin
         noref_seen_r <= 1'b1;
      end
   end

   // count of calibrated points, for diagnostics only through the mode readback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_pts_r <= 2'b00;
      end else if (cal_done && !noref_seen_r && !missing_reference_flag) begin
         cal_pts_r <= cal_pts_r + 2'b01;
      end
   end

   // modulator input switch
   // internal reference switch
   always_comb begin
      insel0 = SDC_IN_PINS;
      insel1 = SDC_IN_PINS;
      if (state_r != SDC_IDLE && is_int) begin
         if (cal_ch_r[0]) begin
            insel0 = is_zero ? SDC_IN_ZERO : SDC_IN_FULL;
         end
         if (cal_ch_r[1]) begin
            insel1 = is_zero ? SDC_IN_ZERO : SDC_IN_FULL;
         end
      end
   end

   // latest filter word of each channel
   logic [W-1:0] last0_r;
   logic [W-1:0] last1_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last0_r <= '0;
         last1_r <= '0;
      end else if (filt.valid) begin
         if (filt.chan) begin
            last1_r <= filt.word;
         end else begin
            last0_r <= filt.word;
         end
      end
   end

   // ==========================================
   // coefficient registers
   logic cal_ok;
   assign cal_ok = cal_done && !noref_seen_r && !missing_reference_flag;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_r <= 1'b0;
         ofs0_r <= '0;
         gain0_r <= SDC_GAIN_UNITY;
         ofs1_r <= '0;
         gain1_r <= SDC_GAIN_UNITY;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         ofs0_r <= fact_ofs0;
         gain0_r <= fact_gain0;
         ofs1_r <= fact_ofs1;
         gain1_r <= fact_gain1;
      end else if (cal_ok) begin
         if (cal_ch_r[0] && is_zero) begin
            ofs0_r <= last0_r;
         end
         if (cal_ch_r[0] && !is_zero) begin
            gain0_r <= norm_gain(last0_r, ofs0_r);
         end
         if (cal_ch_r[1] && is_zero) begin
            ofs1_r <= last1_r;
         end
         if (cal_ch_r[1] && !is_zero) begin
            gain1_r <= norm_gain(last1_r, ofs1_r);
         end
      end
   end

   // full-scale span to unity-normalized gain by a single division, saturated at all ones
   // coefficient normalization
   function automatic logic [W-1:0] norm_gain(input logic [W-1:0] full, input logic [W-1:0] ofs);
      logic [W-1:0] span;
      logic [2*W-1:0] num;
      logic [2*W-1:0] q;
      num = '0;
      q = '0;
      span = (full > ofs) ? full - ofs : '0;
      if (span == '0) begin
         norm_gain = SDC_GAIN_UNITY;
      end else begin
         num = {{W{1'b0}}, {W{1'b1}}} << SDC_GAIN_FRAC;
         q = num / {{W{1'b0}}, span};
         norm_gain = (q > {{W{1'b0}}, {W{1'b1}}}) ? {W{1'b1}} : q[W-1:0];
      end
   endfunction : norm_gain

   // ==========================================
   // normal conversion path
   logic [W-1:0] corr0;
   logic [W-1:0] corr1;
   sdc_corr #(.W(W)) u_corr0 (
      .raw(last0_r),
      .ofs(ofs0_r),
      .gain(gain0_r),
      .res(corr0)
   );
   sdc_corr #(.W(W)) u_corr1 (
      .raw(last1_r),
      .ofs(ofs1_r),
      .gain(gain1_r),
      .res(corr1)
   );
   logic conv0;
   logic conv1;
   logic filt_d_r;
   logic filt_ch_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_d_r <= 1'b0;
         filt_ch_r <= 1'b0;
      end else begin
         filt_d_r <= filt.valid;
         filt_ch_r <= filt.chan;
      end
   end
   // no data update while calibrating
   // data held during calibration
   assign conv0 = filt_d_r && !filt_ch_r && mfield == SDC_MODE_NORMAL && chan_en[0] && state_r == SDC_IDLE;
   assign conv1 = filt_d_r && filt_ch_r && mfield == SDC_MODE_NORMAL && chan_en[1] && state_r == SDC_IDLE;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data0_r <= '0;
         data1_r <= '0;
      end else begin
         if (conv0) begin
            data0_r <= missing_reference_flag ? {W{1'b1}} : corr0;
         end
         if (conv1) begin
            data1_r <= missing_reference_flag ? {W{1'b1}} : corr1;
         end
      end
   end

   // ==========================================
   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 6'h00;
         mask_r <= 4'h0;
         rate_r <= SDC_RATE_RESET;
      end else begin
         if (mode_wr) begin
            mode_r <= pwdata[5:0];
         end else if (cal_done) begin
            mode_r[SDC_MODE_LSB+2:SDC_MODE_LSB] <= SDC_MODE_IDLE;
         end
         if (wr_en && paddr == SDC_MASK_OFF) begin
            mask_r <= pwdata[3:0];
         end
         if (wr_en && paddr == SDC_RATE_OFF) begin
            rate_r <= pwdata[7:0];
         end
      end
   end

   // sticky status, set wins over write-one-clear
   logic [3:0] set_v;
   logic [3:0] clr_v;
   always_comb begin
      set_v = 4'h0;
      set_v[SDC_PRIMARY_READY_FLAG_BIT] = conv0 || (cal_ok && cal_ch_r[0]);
      set_v[SDC_AUXILIARY_READY_FLAG_BIT] = conv1 || (cal_ok && cal_ch_r[1]);
      set_v[SDC_PRIMARY_ERROR_FLAG_BIT] = cal_done && !cal_ok && cal_ch_r[0];
      set_v[SDC_AUXILIARY_ERROR_FLAG_BIT] = cal_done && !cal_ok && cal_ch_r[1];
      clr_v = (wr_en && paddr == SDC_STAT_OFF) ? pwdata[3:0] & SDC_STICKY_MASK : 4'h0;
      // ready dropped when a calibration starts
      if (start) begin
         clr_v[SDC_PRIMARY_READY_FLAG_BIT] = clr_v[SDC_PRIMARY_READY_FLAG_BIT] | pwdata[SDC_EN0_BIT];
         clr_v[SDC_AUXILIARY_READY_FLAG_BIT] = clr_v[SDC_AUXILIARY_READY_FLAG_BIT] | pwdata[SDC_EN1_BIT];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 4'h0;
      end else begin
         stat_r <= (stat_r & ~clr_v) | set_v;
      end
   end
   assign irq = |(stat_r & mask_r);

   // ==========================================
   // read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SDC_MODE_OFF: prdata <= {24'h000000, cal_pts_r, mode_r};
            SDC_STAT_OFF: prdata <= {27'h0, missing_reference_flag, stat_r};
            SDC_MASK_OFF: prdata <= {28'h0000000, mask_r};
            SDC_RATE_OFF: prdata <= {24'h000000, rate_r};
            SDC_DATA0_OFF: prdata <= 32'(data0_r);
            SDC_DATA1_OFF: prdata <= 32'(data1_r);
            SDC_OFS0_OFF: prdata <= 32'(ofs0_r);
            SDC_GAIN0_OFF: prdata <= 32'(gain0_r);
            SDC_OFS1_OFF: prdata <= 32'(ofs1_r);
            SDC_GAIN1_OFF: prdata <= 32'(gain1_r);
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================
   // checks
   // slowest rate held
   cal_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r != SDC_IDLE |-> filter_rate_word == 8'hFF) else $error("calibration not at slowest rate");
   rdy_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      start && pwdata[SDC_EN0_BIT] |=> !stat_r[SDC_PRIMARY_READY_FLAG_BIT]) else $error("ready not cleared at start");
   cal_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      cal_ok && cal_ch_r[0] |=> stat_r[SDC_PRIMARY_READY_FLAG_BIT]) else $error("ready not set after calibration");
   ref_error_a: assert property (@(posedge pclk) disable iff (!presetn)
      cal_done && !cal_ok && cal_ch_r[1] |=> stat_r[SDC_AUXILIARY_ERROR_FLAG_BIT] && $stable(ofs1_r) && $stable(gain1_r))
      else $error("missing reference not flagged");
   ofs_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      loaded_r && cal_ok && cal_ch_r[0] && is_zero |=> ofs0_r == $past(last0_r)) else $error("offset not stored");
   data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r != SDC_IDLE |=> $stable(data0_r) && $stable(data1_r)) else $error("data changed during calibration");
   int_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r != SDC_IDLE && is_int && is_zero && cal_ch_r[0] |-> insel0 == SDC_IN_ZERO)
      else $error("zero reference not switched in");
   fact_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      !loaded_r |=> loaded_r && gain1_r == $past(fact_gain1)) else $error("factory gain not loaded");
endmodule : sdc_cal
`default_nettype wire

// [sdc_mod_model.sv]
// sdc_mod_model: behavioural modulator and digital filter feeding the calibration controller
`timescale 1ns/10ps
`default_nettype none
module sdc_mod_model
   import sdc_pkg::*;
#(
   parameter int PER = 32,
   parameter logic [23:0] ZERO_WORD = 24'h000100,
   parameter logic [23:0] FULL_WORD = 24'hF00100
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire sdc_pkg::sdc_insel_t insel0, // primary input select
   input wire sdc_pkg::sdc_insel_t insel1, // auxiliary input select
   input wire logic [23:0] pin0, // primary pin voltage as a word
   input wire logic [23:0] pin1, // auxiliary pin voltage as a word
   output sdc_pkg::sdc_filt_t filt // filter word out
);
   int cnt;
   logic ch;
   sdc_insel_t sel;
   // ==========================================
   // word source
   assign sel = ch ? insel1 : insel0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         ch <= 1'b0;
         filt <= '0;
      end else if (cnt == PER - 1) begin
         cnt <= 0;
         ch <= !ch;
         filt.valid <= 1'b1;
         filt.chan <= ch;
         filt.word <= (sel == SDC_IN_ZERO) ? ZERO_WORD : (sel == SDC_IN_FULL) ? FULL_WORD : (ch ? pin1 : pin0);
      end else begin
         cnt <= cnt + 1;
         filt.valid <= 1'b0;
         // word is not held once valid drops
         filt.word <= ~filt.word;
      end
   end
endmodule : sdc_mod_model
`default_nettype wire

// [tb.sv]
// tb: register-level test of the converter calibration controller
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sdc_pkg::*;
   localparam logic [23:0] ZW = 24'h000100;
   localparam logic [23:0] FW = 24'hF00100;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
   logic [7:0] paddr = 8'h00, filter_rate_word;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [23:0] pin0 = 24'h012345, pin1 = 24'h000200, g0, g1;
   logic [23:0] fo0 = 24'h000000, fg0 = SDC_GAIN_UNITY, fo1 = 24'h000010, fg1 = 24'h7FFFF0;
   logic mref = 1'b0, filt_restart;
   logic se, rs;
   sdc_filt_t filt;
   sdc_insel_t insel0, insel1;
   int n_fail = 0, compares = 0;
   // ==========================================
   // design and partner
   always #5 pclk = !pclk;
   sdc_cal #(.DIV(1), .W(24)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .filt(filt), .missing_reference_flag(mref), .fact_ofs0(fo0), .fact_gain0(fg0),
      .fact_ofs1(fo1), .fact_gain1(fg1), .insel0(insel0), .insel1(insel1),
      .filter_rate_word(filter_rate_word), .filt_restart(filt_restart), .irq(irq));
   sdc_mod_model #(.PER(32), .ZERO_WORD(ZW), .FULL_WORD(FW)) model (.pclk(pclk), .presetn(presetn),
      .insel0(insel0), .insel1(insel1), .pin0(pin0), .pin1(pin1), .filt(filt));
   // ==========================================
   // tasks
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 100) begin
         n_fail++;
         results();
      end
      rd = prdata;
      se = pslverr;
      rs = filt_restart;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic cal(input logic [7:0] mode, input logic [1:0] s0, input logic [1:0] s1);
      int i;
      xfer(1'b1, SDC_MODE_OFF, {24'h0, mode});
      chk("filter restart", 32'h1, {31'h0, rs});
      @(negedge pclk);
      chk("rate in use", 32'hFF, {24'h0, filter_rate_word});
      chk("insel0", {30'h0, s0}, {30'h0, insel0});
      chk("insel1", {30'h0, s1}, {30'h0, insel1});
      for (i = 0; i < 400; i++) begin
         xfer(1'b0, SDC_MODE_OFF, 32'h0);
         if (rd[2:0] === 3'h0) break;
      end
      if (i == 400) begin
         n_fail++;
         results();
      end
   endtask : cal
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rchk
   // ==========================================
   // sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rchk("rate reset", SDC_RATE_OFF, 32'h45);
      rchk("ofs0 factory", SDC_OFS0_OFF, 32'h0);
      rchk("gain0 factory", SDC_GAIN0_OFF, {8'h0, SDC_GAIN_UNITY});
      rchk("ofs1 factory", SDC_OFS1_OFF, 32'h10);
      rchk("gain1 factory", SDC_GAIN1_OFF, 32'h7FFFF0);
      xfer(1'b1, SDC_MODE_OFF, 32'h11);
      repeat (80) @(posedge pclk);
      xfer(1'b1, SDC_MODE_OFF, 32'h0);
      rchk("data0 unity", SDC_DATA0_OFF, {8'h0, pin0});
      cal(8'h14, 2'(SDC_IN_ZERO), 2'(SDC_IN_PINS));
      rchk("ofs0 zero cal", SDC_OFS0_OFF, {8'h0, ZW});
      rchk("ready after cal", SDC_STAT_OFF, 32'h1);
      xfer(1'b1, SDC_STAT_OFF, 32'hF);
      cal(8'h15, 2'(SDC_IN_FULL), 2'(SDC_IN_PINS));
      g0 = 24'((64'h800000 * 64'hFFFFFF) / 64'(FW - ZW));
      rchk("gain0 full cal", SDC_GAIN0_OFF, {8'h0, g0});
      rchk("data0 kept", SDC_DATA0_OFF, {8'h0, pin0});
      xfer(1'b1, SDC_STAT_OFF, 32'hF);
      // system points are applied at the pins before each start
      pin1 <= 24'h000200;
      cal(8'h26, 2'(SDC_IN_PINS), 2'(SDC_IN_PINS));
      rchk("ofs1 sys zero", SDC_OFS1_OFF, 32'h200);
      pin1 <= 24'hA00200;
      cal(8'h27, 2'(SDC_IN_PINS), 2'(SDC_IN_PINS));
      g1 = 24'((64'h800000 * 64'hFFFFFF) / 64'h00A00000);
      rchk("gain1 sys full", SDC_GAIN1_OFF, {8'h0, g1});
      rchk("ofs0 kept", SDC_OFS0_OFF, {8'h0, ZW});
      rchk("aux ready", SDC_STAT_OFF, 32'h2);
      xfer(1'b1, SDC_STAT_OFF, 32'hF);
      mref <= 1'b1;
      cal(8'h34, 2'(SDC_IN_ZERO), 2'(SDC_IN_ZERO));
      rchk("ofs0 blocked", SDC_OFS0_OFF, {8'h0, ZW});
      rchk("ofs1 blocked", SDC_OFS1_OFF, 32'h200);
      rchk("err set", SDC_STAT_OFF, 32'h1C);
      mref <= 1'b0;
      xfer(1'b1, SDC_STAT_OFF, 32'hF);
      pin0 <= 24'h100100;
      xfer(1'b1, SDC_MODE_OFF, 32'h11);
      repeat (80) @(posedge pclk);
      xfer(1'b1, SDC_MODE_OFF, 32'h0);
      rchk("data0 corrected", SDC_DATA0_OFF, {8'h0, 24'((64'h100000 * 64'(g0)) >> 23)});
      xfer(1'b1, SDC_MASK_OFF, 32'h1);
      @(negedge pclk);
      chk("irq masked in", 32'h1, {31'h0, irq});
      xfer(1'b1, SDC_STAT_OFF, 32'h1);
      @(negedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      xfer(1'b0, 8'h30, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, se});
      chk("unmapped data", 32'h0, rd);
      // second reset in mid-run with other factory values
      fo0 <= 24'h000030;
      fg1 <= 24'h7FFF00;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rchk("ofs0 reload", SDC_OFS0_OFF, 32'h30);
      rchk("gain1 reload", SDC_GAIN1_OFF, 32'h7FFF00);
      rchk("rate after reset", SDC_RATE_OFF, 32'h45);
      rchk("stat after reset", SDC_STAT_OFF, 32'h0);
      results();
   end
endmodule : tb
`default_nettype wire
